/* File: design/dio_top.sv */
// Digital I/O channel block: direction, stop reaction, filter, irq, diag
//
// Function
// - Module-specific alarms go out only while group diagnostics are on.
// - Fault and parameter errors are always reported, group enable or not.
// - Wire break on an enabled output channel raises a diagnostic event.
// - Missing load voltage is flagged only while its diagnostic is enabled.
// - Module short-circuit checking runs only while its enable is set.
// - Short to supply on an enabled output channel raises a diagnostic event.
// - Input-side short enable checks the encoder supply for ground short.
// - Output-side short enable checks output signals for ground short.
// - Encoder supply short to ground raises an event when enabled.
// - Input pulses no longer than the chosen delay are ignored.
// - Channel edge interrupts issue only under the module interrupt enable.
// - Falling input edge on a selected channel triggers an interrupt.
// - Rising input edge on a selected channel triggers an interrupt.
// - Each channel works as input or output per its direction bit.
// - Shutdown reaction de-energizes outputs while the controller is stopped.
// - Hold reaction keeps the last output value during stop.
// - Substitute reaction drives each output's substitute bit during stop.
// - Mixed variant reports encoder and output ground shorts as one error.
`timescale 1ns/1ns
module dio_top
  import dio_pkg::*;
#(
  parameter int NCH = dio_pkg::DIO_NCH,
  parameter bit MIXED = 1'b1,
  parameter int DLY0_CYC = dio_pkg::DLY0_US * dio_pkg::DIO_CLK_MHZ,
  parameter int DLY1_CYC = dio_pkg::DLY1_US * dio_pkg::DIO_CLK_MHZ,
  parameter int DLY2_CYC = dio_pkg::DLY2_US * dio_pkg::DIO_CLK_MHZ,
  parameter int DLY3_CYC = dio_pkg::DLY3_US * dio_pkg::DIO_CLK_MHZ
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [dio_pkg::DIO_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [dio_pkg::DIO_DW-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [dio_pkg::DIO_DW-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [NCH-1:0] din_i,
  output logic [NCH-1:0] dout_o,
  output logic [NCH-1:0] dout_oe_o,
  input wire logic [NCH-1:0] wire_break_i,
  input wire logic [NCH-1:0] short_gnd_i,
  input wire logic [NCH-1:0] short_sup_i,
  input wire logic load_volt_ok_i,
  input wire logic enc_short_i,
  input wire logic fault_i,
  output logic diag_alarm_o,
  output logic irq_o
);
  import dio_pkg::*;

  localparam int PW = 4 * NCH + 3;

  logic [31:0] cfg;
  logic [31:0] chcfg;
  logic [NCH-1:0] out_val;
  logic [NCH-1:0] hold_val;
  logic [IS_W-1:0] irq_st;
  logic [IS_W-1:0] irq_msk;
  logic [DG_W-1:0] diag;
  logic [DG_W-1:0] next_diag;
  logic [PW-1:0] pin_meta;
  logic [PW-1:0] pin_sync;
  logic [NCH-1:0] filt;
  logic [NCH-1:0] filt_d;
  logic [DIO_DB_W-1:0] lim;
  dio_bus_state_type bus_st;
  logic [31:0] rd_mux;
  logic [31:0] be_mask;
  logic wr_go;

  wire logic [NCH-1:0] s_din = pin_sync[NCH-1:0];
  wire logic [NCH-1:0] s_wb = pin_sync[2*NCH-1:NCH];
  wire logic [NCH-1:0] s_sgnd = pin_sync[3*NCH-1:2*NCH];
  wire logic [NCH-1:0] s_ssup = pin_sync[4*NCH-1:3*NCH];
  wire logic s_load_ok = pin_sync[4*NCH];
  wire logic s_enc = pin_sync[4*NCH+1];
  wire logic s_fault = pin_sync[4*NCH+2];

  wire logic [NCH-1:0] dir = chcfg[CH_DIR +: NCH];
  wire logic [NCH-1:0] subst = chcfg[CH_SUBST +: NCH];
  wire logic [1:0] react = cfg[CFG_REACT +: 2];
  wire logic stopped = cfg[CFG_STOP];
  wire logic hw_en = cfg[CFG_HWIRQ];

  // Pin inputs: two flops before any logic looks at them
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {fault_i, enc_short_i, load_volt_ok_i, short_sup_i,
                   short_gnd_i, wire_break_i, din_i};
      pin_sync <= pin_meta;
    end
  end

  // Bus slave: one wait state, then the answer
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_st <= BUS_IDLE;
    end else begin
      unique case (bus_st)
        BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_st <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          bus_st <= BUS_IDLE;
        end
      endcase
    end
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) &&
                             (bus_st != BUS_ACK);
  assign wr_go = avs_write_i && (bus_st == BUS_ACK);

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      be_mask[8*b +: 8] = {8{avs_byteenable_i[b]}};
    end
  end

  // Unmapped offsets read as zero and ignore writes
  always_comb begin
    rd_mux = '0;
    unique case (avs_address_i)
      OFS_CFG: rd_mux = cfg;
      OFS_CHCFG: rd_mux = chcfg;
      OFS_OUT: rd_mux[NCH-1:0] = out_val;
      OFS_IN: rd_mux[NCH-1:0] = filt;
      OFS_DIAG: rd_mux[DG_W-1:0] = diag;
      OFS_IST: rd_mux[IS_W-1:0] = irq_st;
      OFS_IMSK: rd_mux[IS_W-1:0] = irq_msk;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_readdata_o <= '0;
    end else if (avs_read_i && bus_st == BUS_IDLE) begin
      avs_readdata_o <= rd_mux;
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg <= CFG_RST;
      chcfg <= CHCFG_RST;
      out_val <= '0;
      irq_msk <= '0;
    end else if (wr_go) begin
      unique case (avs_address_i)
        OFS_CFG: cfg <= (cfg & ~be_mask) | (avs_writedata_i & be_mask);
        OFS_CHCFG: begin
          chcfg <= (chcfg & ~be_mask) | (avs_writedata_i & be_mask);
        end
        OFS_OUT: begin
          if (avs_byteenable_i[0]) begin
            out_val <= avs_writedata_i[NCH-1:0];
          end
        end
        OFS_IMSK: begin
          if (avs_byteenable_i[0]) begin
            irq_msk <= avs_writedata_i[IS_W-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Input filter: a level is taken only after it has stood for the delay
  always_comb begin
    unique case (cfg[CFG_DLY +: 2])
      2'h0: lim = DIO_DB_W'(DLY0_CYC);
      2'h1: lim = DIO_DB_W'(DLY1_CYC);
      2'h2: lim = DIO_DB_W'(DLY2_CYC);
      default: lim = DIO_DB_W'(DLY3_CYC);
    endcase
  end

  for (genvar c = 0; c < NCH; c++) begin : g_filt
    logic [DIO_DB_W-1:0] cnt;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        cnt <= '0;
        filt[c] <= 1'b0;
      end else if (s_din[c] == filt[c]) begin
        cnt <= '0;
      end else if (cnt >= lim) begin
        filt[c] <= s_din[c];
        cnt <= '0;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      filt_d <= '0;
    end else begin
      filt_d <= filt;
    end
  end

  // Diagnostic conditions, live while the fault stands
  always_comb begin
    next_diag = '0;
    next_diag[DG_WB +: NCH] = s_wb & dir & chcfg[CH_WB +: NCH];
    next_diag[DG_SSUP +: NCH] = s_ssup & dir & chcfg[CH_SSUP +: NCH];
    next_diag[DG_LOAD] = cfg[CFG_LOAD] && !s_load_ok;
    next_diag[DG_SHORT] = cfg[CFG_SHORT] && |(s_sgnd & dir);
    next_diag[DG_ENC] = cfg[CFG_ENC] && s_enc;
    next_diag[DG_OGND] = cfg[CFG_OGND] && |(s_sgnd & dir);
    next_diag[DG_COMMON] = MIXED &&
                           (next_diag[DG_ENC] || next_diag[DG_OGND]);
    next_diag[DG_FAULT] = s_fault;
    // Reaction code 3 has no meaning and counts as a parameter error
    next_diag[DG_PERR] = (react == 2'h3);
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      diag <= '0;
    end else begin
      diag <= next_diag;
    end
  end

  wire logic [DG_W-1:0] rep_mask = {2'b11, {(DG_W-2){cfg[CFG_GRP]}}};

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      diag_alarm_o <= 1'b0;
    end else begin
      diag_alarm_o <= |(diag & rep_mask);
    end
  end

  // Sticky status; a new event beats a write-one-to-clear
  wire logic [NCH-1:0] rise_ev = filt & ~filt_d & ~dir & chcfg[CH_RISE +: NCH];
  wire logic [NCH-1:0] fall_ev = ~filt & filt_d & ~dir & chcfg[CH_FALL +: NCH];
  wire logic diag_ev = |((diag ^ next_diag) & rep_mask);
  wire logic [IS_W-1:0] set_ev = {diag_ev,
                                  {NCH{hw_en}} & (rise_ev | fall_ev)};

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_st <= '0;
    end else begin
      if (wr_go && avs_address_i == OFS_IST && avs_byteenable_i[0]) begin
        irq_st <= (irq_st & ~avs_writedata_i[IS_W-1:0]) | set_ev;
      end else begin
        irq_st <= irq_st | set_ev;
      end
    end
  end

  assign irq_o = |(irq_st & irq_msk);

  // Outputs and their stop reaction; the hold copy freezes at stop entry
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hold_val <= '0;
    end else if (!stopped) begin
      hold_val <= out_val;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dout_o <= '0;
      dout_oe_o <= '0;
    end else begin
      dout_oe_o <= dir;
      if (!stopped) begin
        dout_o <= out_val & dir;
      end else if (react == REACT_HOLD) begin
        dout_o <= hold_val & dir;
      end else if (react == REACT_SUBST) begin
        dout_o <= subst & dir;
      end else begin
        dout_o <= '0;
      end
    end
  end

  AST_GROUP_GATE: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (!cfg[CFG_GRP] && !diag[DG_FAULT] && !diag[DG_PERR]) |=> !diag_alarm_o)
    else $error("Alarm raised with group diagnostics off");

  AST_FAULT_ALWAYS: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    diag[DG_FAULT] |=> diag_alarm_o)
    else $error("Fault not reported");

  AST_WIRE_BREAK: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (s_wb[0] && dir[0] && chcfg[CH_WB]) |=> diag[DG_WB])
    else $error("Wire break on channel 0 missed");

  AST_LOAD_OFF: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !cfg[CFG_LOAD] |=> !diag[DG_LOAD])
    else $error("Load voltage flagged while disabled");

  AST_ENC_SHORT: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (cfg[CFG_ENC] && s_enc) |=> diag[DG_ENC] ##1 diag_alarm_o || !cfg[CFG_GRP])
    else $error("Encoder short not reported");

  AST_FILTER: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (filt[0] != $past(filt[0])) |-> $past(s_din[0], 2) == filt[0])
    else $error("Filter took a level that had not stood");

  AST_IRQ_GATE: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    $rose(irq_st[0]) |-> $past(hw_en))
    else $error("Edge interrupt without module enable");

  AST_RISE_IRQ: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (hw_en && rise_ev[0]) |=> irq_st[0])
    else $error("Rising edge interrupt lost");

  AST_SHUTDOWN: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (stopped && react == REACT_SHUT) |=> dout_o == '0)
    else $error("Outputs live during stop with shutdown");

  AST_HOLD: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (stopped && $past(stopped) && react == REACT_HOLD && $stable(dir))
    |=> $stable(dout_o))
    else $error("Held outputs changed during stop");

  AST_SUBST: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (stopped && react == REACT_SUBST) |=> dout_o == $past(subst & dir))
    else $error("Substitute value not driven");

  AST_COMMON_ERR: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (diag[DG_ENC] || diag[DG_OGND]) |-> diag[DG_COMMON] == MIXED)
    else $error("Common error bit disagrees");

  AST_SHORT_OFF: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !cfg[CFG_SHORT] |=> !diag[DG_SHORT])
    else $error("Module short flagged while disabled");

  AST_SUPPLY_SHORT: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (s_ssup[1] && dir[1] && chcfg[CH_SSUP+1]) |=> diag[DG_SSUP+1])
    else $error("Short to supply on channel 1 missed");

  AST_FALL_IRQ: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (hw_en && fall_ev[0]) |=> irq_st[0])
    else $error("Falling edge interrupt lost");

  AST_DIRECTION: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    1'b1 |=> dout_oe_o == $past(dir) && (dout_o & ~dout_oe_o) == '0)
    else $error("Channel direction not honoured");

  AST_BUS_ANSWER: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (bus_st == BUS_IDLE && avs_read_i) |=> !avs_waitrequest_o)
    else $error("Bus answer late");
endmodule : dio_top

/* File: shared/dio_pkg.sv */
// Constants shared by the digital I/O channel block
package dio_pkg;
  localparam int DIO_NCH = 4;
  localparam int DIO_AW = 8;
  localparam int DIO_DW = 32;
  localparam int DIO_CLK_MHZ = 100;
  localparam int DIO_DB_W = 21;

  // Register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_CHCFG = 8'h04;
  localparam logic [7:0] OFS_OUT = 8'h08;
  localparam logic [7:0] OFS_IN = 8'h0C;
  localparam logic [7:0] OFS_DIAG = 8'h10;
  localparam logic [7:0] OFS_IST = 8'h14;
  localparam logic [7:0] OFS_IMSK = 8'h18;

  // Module configuration fields
  localparam int CFG_GRP = 0;
  localparam int CFG_LOAD = 1;
  localparam int CFG_SHORT = 2;
  localparam int CFG_ENC = 3;
  localparam int CFG_OGND = 4;
  localparam int CFG_HWIRQ = 5;
  localparam int CFG_REACT = 6;
  localparam int CFG_DLY = 8;
  localparam int CFG_STOP = 10;
  localparam logic [31:0] CFG_RST = 32'h0000_0100;

  // Channel configuration fields, each DIO_NCH bits wide
  localparam int CH_DIR = 0;
  localparam int CH_SUBST = 4;
  localparam int CH_WB = 8;
  localparam int CH_SSUP = 12;
  localparam int CH_RISE = 16;
  localparam int CH_FALL = 20;
  localparam logic [31:0] CHCFG_RST = 32'h0000_0000;

  // Diagnostic condition bits
  localparam int DG_WB = 0;
  localparam int DG_SSUP = 4;
  localparam int DG_LOAD = 8;
  localparam int DG_SHORT = 9;
  localparam int DG_ENC = 10;
  localparam int DG_OGND = 11;
  localparam int DG_COMMON = 12;
  localparam int DG_FAULT = 13;
  localparam int DG_PERR = 14;
  localparam int DG_W = 15;

  // Interrupt status bits: channel edges, then diagnostic change
  localparam int IS_DIAG = 4;
  localparam int IS_W = 5;

  // Stop reaction codes
  localparam logic [1:0] REACT_SHUT = 2'h0;
  localparam logic [1:0] REACT_HOLD = 2'h1;
  localparam logic [1:0] REACT_SUBST = 2'h2;

  // Input delay settings in microseconds, by code 0..3
  localparam int DLY0_US = 500;
  localparam int DLY1_US = 3000;
  localparam int DLY2_US = 15000;
  localparam int DLY3_US = 20000;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } dio_bus_state_type;
endpackage : dio_pkg

/* File: sim/dio_host.sv */
// Register-bus master standing in for the controlling CPU
`timescale 1ns/1ns
module dio_host
  import dio_pkg::*;
(
  input wire logic clk_i,
  input wire logic waitrequest_i,
  input wire logic [dio_pkg::DIO_DW-1:0] readdata_i,
  output logic [dio_pkg::DIO_AW-1:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [dio_pkg::DIO_DW-1:0] writedata_o,
  output logic [3:0] byteenable_o
);
  initial begin
    address_o <= 8'h00;
    read_o <= 1'b0;
    write_o <= 1'b0;
    writedata_o <= 32'h0;
    byteenable_o <= 4'hF;
  end

  task automatic xfer(input logic is_wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    q = 32'hX;
    @(posedge clk_i);
    address_o <= a;
    writedata_o <= d;
    read_o <= !is_wr;
    write_o <= is_wr;
    // Waitrequest and read data are both taken at the completing edge;
    // only the bench watchdog ends a wait that never finishes
    do begin
      @(posedge clk_i);
    end while (waitrequest_i !== 1'b0);
    q = readdata_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
    // Idle lines must not keep looking like a valid request
    address_o <= ~a;
    writedata_o <= ~d;
  endtask : xfer
endmodule : dio_host

/* File: sim/dio_top_tb.sv */
// Self-checking bench for the digital I/O channel block
`timescale 1ns/1ns
module dio_top_tb;
  import dio_pkg::*;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [DIO_AW-1:0] adr;
  logic rd;
  logic wr;
  logic [DIO_DW-1:0] wd;
  logic [3:0] be;
  logic [DIO_DW-1:0] rdata;
  logic wreq;
  logic [3:0] din = 4'h0;
  logic [3:0] dout;
  logic [3:0] doe;
  logic [3:0] wb = 4'h0;
  logic [3:0] sg = 4'h0;
  logic [3:0] ss = 4'h0;
  logic lv_ok = 1'b1;
  logic enc = 1'b0;
  logic flt = 1'b0;
  logic alarm;
  logic irq;
  int n_fail = 0;
  int samples_checked = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  dio_top #(.DLY0_CYC(3), .DLY1_CYC(5), .DLY2_CYC(8), .DLY3_CYC(10)) DUT (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .din_i(din), .dout_o(dout),
    .dout_oe_o(doe), .wire_break_i(wb), .short_gnd_i(sg),
    .short_sup_i(ss), .load_volt_ok_i(lv_ok), .enc_short_i(enc),
    .fault_i(flt), .diag_alarm_o(alarm), .irq_o(irq));

  dio_host host (
    .clk_i(ref_clk_i), .waitrequest_i(wreq), .readdata_i(rdata),
    .address_o(adr), .read_o(rd), .write_o(wr), .writedata_o(wd),
    .byteenable_o(be));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask : reg_wr

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : reg_chk

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : settle

  task automatic dg(input logic [3:0] w, input logic [3:0] g,
                    input logic [3:0] s, input logic l, input logic e,
                    input logic f, input logic [31:0] exp);
    @(posedge ref_clk_i);
    wb <= w;
    sg <= g;
    ss <= s;
    lv_ok <= l;
    enc <= e;
    flt <= f;
    settle(6);
    reg_chk(OFS_DIAG, exp);
  endtask : dg

  task automatic t_reset();
    chk(32'(doe), 32'h0);
    reg_chk(OFS_CFG, 32'h0000_0100);
    reg_chk(OFS_CHCFG, 32'h0);
    reg_chk(8'h1C, 32'h0);
  endtask : t_reset

  task automatic t_stop();
    reg_wr(OFS_CHCFG, 32'h0000_0023);
    reg_wr(OFS_OUT, 32'hF);
    settle(2);
    chk(32'(doe), 32'h3);
    chk(32'(dout), 32'h3);
    reg_wr(OFS_CFG, 32'h0000_0500);
    settle(2);
    chk(32'(dout), 32'h0);
    reg_wr(OFS_CFG, 32'h0000_0140);
    reg_wr(OFS_CFG, 32'h0000_0540);
    reg_wr(OFS_OUT, 32'h0);
    settle(2);
    chk(32'(dout), 32'h3);
    reg_wr(OFS_CFG, 32'h0000_0580);
    settle(2);
    chk(32'(dout), 32'h2);
    reg_wr(OFS_CFG, 32'h0000_0100);
    settle(2);
    chk(32'(dout), 32'h0);
  endtask : t_stop

  task automatic t_diag();
    reg_wr(OFS_CHCFG, 32'h0000_2103);
    reg_wr(OFS_CFG, 32'h0000_011E);
    dg(4'h1, 4'h0, 4'h0, 1'b1, 1'b0, 1'b0, 32'h0000_0001);
    chk(32'(alarm), 32'h0);
    dg(4'h1, 4'h0, 4'h0, 1'b1, 1'b0, 1'b1, 32'h0000_2001);
    chk(32'(alarm), 32'h1);
    dg(4'h0, 4'h0, 4'h0, 1'b1, 1'b0, 1'b0, 32'h0);
    chk(32'(alarm), 32'h0);
    reg_wr(OFS_CFG, 32'h0000_011B);
    reg_wr(OFS_IST, 32'h1F);
    reg_wr(OFS_IMSK, 32'h10);
    dg(4'h0, 4'h0, 4'h2, 1'b1, 1'b0, 1'b0, 32'h0000_0020);
    chk(32'(alarm), 32'h1);
    chk(32'(irq), 32'h1);
    reg_wr(OFS_IST, 32'h1F);
    dg(4'h0, 4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 32'h0000_0100);
    dg(4'h0, 4'h0, 4'h0, 1'b1, 1'b1, 1'b0, 32'h0000_1400);
    dg(4'h0, 4'h1, 4'h0, 1'b1, 1'b0, 1'b0, 32'h0000_1800);
    reg_wr(OFS_CFG, 32'h0000_011F);
    dg(4'h0, 4'h1, 4'h0, 1'b1, 1'b0, 1'b0, 32'h0000_1A00);
    reg_wr(OFS_CFG, 32'h0000_0101);
    dg(4'h0, 4'h1, 4'h0, 1'b0, 1'b1, 1'b0, 32'h0);
    dg(4'h0, 4'h0, 4'h0, 1'b1, 1'b0, 1'b0, 32'h0);
  endtask : t_diag

  task automatic t_irq();
    reg_wr(OFS_CHCFG, 32'h0001_0000);
    reg_wr(OFS_CFG, 32'h0000_0120);
    reg_wr(OFS_IST, 32'h1F);
    reg_wr(OFS_IMSK, 32'h01);
    @(posedge ref_clk_i);
    din <= 4'h1;
    // A pulse as long as the delay setting must vanish
    settle(5);
    din <= 4'h0;
    settle(12);
    reg_chk(OFS_IN, 32'h0);
    reg_chk(OFS_IST, 32'h0);
    din <= 4'h1;
    settle(20);
    reg_chk(OFS_IN, 32'h1);
    reg_chk(OFS_IST, 32'h1);
    chk(32'(irq), 32'h1);
    reg_wr(OFS_IST, 32'h1F);
    // The clear lands at the edge that ends the write; look one edge later
    settle(1);
    chk(32'(irq), 32'h0);
    reg_wr(OFS_CHCFG, 32'h0010_0000);
    din <= 4'h0;
    settle(20);
    reg_chk(OFS_IST, 32'h1);
    reg_wr(OFS_IST, 32'h1F);
    reg_wr(OFS_CFG, 32'h0000_0100);
    reg_wr(OFS_CHCFG, 32'h0011_0000);
    din <= 4'h1;
    settle(20);
    reg_chk(OFS_IST, 32'h0);
    chk(32'(irq), 32'h0);
  endtask : t_irq

  task automatic summarize();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // Whole run needs a few hundred cycles; this margin only cuts hangs
  initial begin
    settle(20000);
    n_fail++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    settle(12);
    arst_n_i <= 1'b1;
    t_reset();
    t_stop();
    t_diag();
    t_irq();
    summarize();
  end
endmodule : dio_top_tb
